// ==== common/lmsc_pkg.sv ====
// Package of constants for the LED matrix scan core.
// Assumes a single 125 MHz clock and an AXI4-Lite register slave.
package lmsc_pkg;
    // ----------------------------------------------------------------
    // Matrix geometry
    // ----------------------------------------------------------------
    localparam int LINES       = 9;
    localparam int COLS        = 8;
    localparam int GRAY_BYTES  = 72;
    localparam logic [3:0] LAST_LINE     = 4'h8;
    localparam logic [7:0] BIN_LAST_ADDR = 8'h08;
    localparam logic [7:0] GRAY_LAST_ADDR = 8'h87;
    localparam logic [7:0] ADDR_WRAP     = 8'h00;
    localparam logic [3:0] GRAY_COL_LIMIT = 4'h8;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ      = 125_000_000;
    localparam int FRAME_HZ    = 980;
    localparam int PHASE_CYCLES_DEF = CLK_HZ / (FRAME_HZ * LINES);

    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [11:0] REG_CTRL   = 12'h000;
    localparam logic [11:0] REG_PTR    = 12'h004;
    localparam logic [11:0] REG_DATA   = 12'h008;
    localparam logic [11:0] REG_STATUS = 12'h00C;
    localparam logic [5:0]  BLK_CORE   = 6'h00;
    localparam logic [5:0]  BLK_OMASK  = 6'h01;
    localparam logic [5:0]  BLK_SMASK  = 6'h02;
    localparam logic [5:0]  BLK_ORES   = 6'h03;
    localparam logic [5:0]  BLK_SRES   = 6'h04;

    // CTRL fields
    localparam int CTRL_OSC  = 0;
    localparam int CTRL_DISP = 1;
    localparam int CTRL_GRAY = 2;
    localparam int CTRL_DET  = 3;
    // STATUS fields
    localparam int STAT_TSD  = 0;
    localparam int STAT_BUSY = 1;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Decoded register kinds
    typedef enum logic [3:0] {
        RK_NONE   = 4'b0000,
        RK_CTRL   = 4'b0001,
        RK_PTR    = 4'b0010,
        RK_DATA   = 4'b0011,
        RK_STATUS = 4'b0100,
        RK_OMASK  = 4'b0101,
        RK_SMASK  = 4'b0110,
        RK_ORES   = 4'b0111,
        RK_SRES   = 4'b1000
    } lmsc_kind_t;
endpackage

// ==== src/lmsc_core.sv ====
// LED matrix scan core: display memory, 1/9 multiplex scan, open/short
// detection and thermal blanking behind an AXI4-Lite register slave.
// Assumes all inputs synchronous to aclk; pins resolved by the bench.
//
// Register access over AXI4-Lite and the placing of the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - Reset restores registers, keeps display memory; open and short masks also kept
// - Oscillator stopped after reset until started
// - Reset leaves all line pins and sync Hi-Z
// - Display off after reset
// - Nine lines, each active one ninth
// - Pin sinks, drives high, or floats
// - Pin pattern comes from display latch
// - Set pointer, then write bytes in sequence
// - Detection steps on serial clock pulses
// - Step lines in order, check other pins
// - Open and short results readable separately
// - Open reported only where open mask set
// - Short reported only where short mask set
// - Overheat sets flag, blanks, pins off
// - Cooling clears flag, display resumes
// - Binary: nine words, bit per LED
// - Binary address wraps after 08h
// - Gray: one byte per LED, row nibble
// - Gray address wraps after 87h
module lmsc_core #(
    parameter int PHASE_CYCLES = lmsc_pkg::PHASE_CYCLES_DEF
) (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Analog side
    input  wire logic        over_temp,
    input  wire logic        serial_clk,
    input  wire logic [8:0]  open_cmp,
    input  wire logic [8:0]  short_cmp,
    // Matrix line pins and cascade sync
    output logic [8:0]       matrix_line_pins_o,
    output logic [8:0]       matrix_line_pins_oe,
    output logic             sync_o,
    output logic             sync_oe,
    output logic             thermal_shutdown_flag
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic              ctrl_osc;
        logic              ctrl_disp;
        logic              ctrl_gray;
        logic              ctrl_det;
        logic [7:0]        ptr;
        logic [8:0][7:0]   bin_mem;
        logic [71:0][7:0]  gray_mem;
        logic [8:0][7:0]   omask;
        logic [8:0][7:0]   smask;
        logic [8:0][7:0]   ores;
        logic [8:0][7:0]   sres;
        logic              tsd;
        logic [3:0]        line;
        logic [15:0]       ph_cnt;
        logic [7:0]        latch;
        logic              det_busy;
        logic              det_act;
        logic [3:0]        det_line;
        logic              scl_q;
        logic [8:0]        pin_out;
        logic [8:0]        pin_oe;
        logic              sync_out;
        logic              aw_full;
        logic              w_full;
        logic [11:0]       aw_addr;
        logic [7:0]        w_data;
        logic              w_lane0;
        logic              awready;
        logic              wready;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
    } lmsc_state_t;

    lmsc_state_t s_r;
    lmsc_state_t s_nxt;
    logic        wr_go;
    logic        rd_go;

    localparam logic [15:0] PH_LAST = 16'(PHASE_CYCLES - 1);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic lmsc_pkg::lmsc_kind_t reg_kind(input logic [11:0] a);
        lmsc_pkg::lmsc_kind_t k;
        k = lmsc_pkg::RK_NONE;
        if (a[1:0] == 2'b00) begin
            if (a[11:6] == lmsc_pkg::BLK_CORE) begin
                case (a)
                    lmsc_pkg::REG_CTRL:   k = lmsc_pkg::RK_CTRL;
                    lmsc_pkg::REG_PTR:    k = lmsc_pkg::RK_PTR;
                    lmsc_pkg::REG_DATA:   k = lmsc_pkg::RK_DATA;
                    lmsc_pkg::REG_STATUS: k = lmsc_pkg::RK_STATUS;
                    default:              k = lmsc_pkg::RK_NONE;
                endcase
            end else if (a[5:2] <= lmsc_pkg::LAST_LINE) begin
                case (a[11:6])
                    lmsc_pkg::BLK_OMASK: k = lmsc_pkg::RK_OMASK;
                    lmsc_pkg::BLK_SMASK: k = lmsc_pkg::RK_SMASK;
                    lmsc_pkg::BLK_ORES:  k = lmsc_pkg::RK_ORES;
                    lmsc_pkg::BLK_SRES:  k = lmsc_pkg::RK_SRES;
                    default:             k = lmsc_pkg::RK_NONE;
                endcase
            end
        end
        return k;
    endfunction

    // Gray address is mapped only for rows 0..8 and low nibble 0..7
    function automatic logic gray_mapped(input logic [7:0] p);
        return (p[7:4] <= lmsc_pkg::LAST_LINE) && (p[3:0] < lmsc_pkg::GRAY_COL_LIMIT);
    endfunction

    function automatic logic [7:0] ptr_step(input logic gray, input logic [7:0] p);
        logic [7:0] last;
        last = gray ? lmsc_pkg::GRAY_LAST_ADDR : lmsc_pkg::BIN_LAST_ADDR;
        return (p >= last) ? lmsc_pkg::ADDR_WRAP : 8'(p + 8'h01);
    endfunction

    // Column index of pin p while line a is the active one
    function automatic logic [2:0] pin_col(input logic [3:0] a, input logic [3:0] p);
        return (p < a) ? p[2:0] : 3'(p - 4'h1);
    endfunction

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        lmsc_state_t n;
        logic [7:0]  rd_byte;
        logic [6:0]  gidx;
        logic        running;
        lmsc_pkg::lmsc_kind_t wk;
        lmsc_pkg::lmsc_kind_t rk;
        n       = s_r;
        rd_byte = 8'h00;
        gidx    = 7'h00;
        running = 1'b0;
        wk      = reg_kind(s_r.aw_addr);
        rk      = reg_kind(s_axi_araddr);

        // Write channel capture, either order
        if (s_axi_awvalid && s_r.awready) begin
            n.aw_full = 1'b1;
            n.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_r.wready) begin
            n.w_full  = 1'b1;
            n.w_data  = s_axi_wdata[7:0];
            n.w_lane0 = s_axi_wstrb[0];
        end
        if (s_r.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
        end
        wr_go = s_r.aw_full && s_r.w_full && !s_r.bvalid;
        if (wr_go) begin
            n.aw_full = 1'b0;
            n.w_full  = 1'b0;
            n.bvalid  = 1'b1;
            n.bresp   = (wk == lmsc_pkg::RK_NONE) ? lmsc_pkg::RESP_SLVERR : lmsc_pkg::RESP_OKAY;
            if (s_r.w_lane0) begin
                case (wk)
                    lmsc_pkg::RK_CTRL: begin
                        n.ctrl_osc  = s_r.w_data[lmsc_pkg::CTRL_OSC];
                        n.ctrl_disp = s_r.w_data[lmsc_pkg::CTRL_DISP];
                        n.ctrl_gray = s_r.w_data[lmsc_pkg::CTRL_GRAY];
                        n.ctrl_det  = s_r.w_data[lmsc_pkg::CTRL_DET];
                        if (s_r.w_data[lmsc_pkg::CTRL_DET] && !s_r.ctrl_det) begin
                            n.det_busy = 1'b1;
                            n.det_act  = 1'b0;
                            n.det_line = 4'h0;
                        end
                    end
                    lmsc_pkg::RK_PTR: n.ptr = s_r.w_data;
                    lmsc_pkg::RK_DATA: begin
                        if (!s_r.ctrl_gray) begin
                            if (s_r.ptr <= lmsc_pkg::BIN_LAST_ADDR) begin
                                n.bin_mem[s_r.ptr[3:0]] = s_r.w_data;
                            end
                        end else if (gray_mapped(s_r.ptr)) begin
                            n.gray_mem[{s_r.ptr[7:4], s_r.ptr[2:0]}] = s_r.w_data;
                        end
                        n.ptr = ptr_step(s_r.ctrl_gray, s_r.ptr);
                    end
                    lmsc_pkg::RK_OMASK: n.omask[s_r.aw_addr[5:2]] = s_r.w_data;
                    lmsc_pkg::RK_SMASK: n.smask[s_r.aw_addr[5:2]] = s_r.w_data;
                    default: ;
                endcase
            end
        end

        // Read channel; sees the pointer after any write of this cycle
        if (s_r.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
        end
        rd_go = s_axi_arvalid && s_r.arready;
        if (rd_go) begin
            n.rvalid = 1'b1;
            n.rresp  = (rk == lmsc_pkg::RK_NONE) ? lmsc_pkg::RESP_SLVERR : lmsc_pkg::RESP_OKAY;
            case (rk)
                lmsc_pkg::RK_CTRL:   rd_byte = {4'h0, s_r.ctrl_det, s_r.ctrl_gray, s_r.ctrl_disp, s_r.ctrl_osc};
                lmsc_pkg::RK_PTR:    rd_byte = n.ptr;
                lmsc_pkg::RK_STATUS: rd_byte = {6'h00, s_r.det_busy, s_r.tsd};
                lmsc_pkg::RK_DATA: begin
                    if (!s_r.ctrl_gray) begin
                        rd_byte = (n.ptr <= lmsc_pkg::BIN_LAST_ADDR) ? n.bin_mem[n.ptr[3:0]] : 8'h00;
                    end else if (gray_mapped(n.ptr)) begin
                        rd_byte = n.gray_mem[{n.ptr[7:4], n.ptr[2:0]}];
                    end
                    n.ptr = ptr_step(s_r.ctrl_gray, n.ptr);
                end
                lmsc_pkg::RK_OMASK: rd_byte = s_r.omask[s_axi_araddr[5:2]];
                lmsc_pkg::RK_SMASK: rd_byte = s_r.smask[s_axi_araddr[5:2]];
                lmsc_pkg::RK_ORES:  rd_byte = s_r.ores[s_axi_araddr[5:2]];
                lmsc_pkg::RK_SRES:  rd_byte = s_r.sres[s_axi_araddr[5:2]];
                default:            rd_byte = 8'h00;
            endcase
            n.rdata = {24'h00_0000, rd_byte};
        end

        n.aw_full = n.aw_full;
        n.awready = !n.aw_full && !n.bvalid;
        n.wready  = !n.w_full && !n.bvalid;
        n.arready = !n.rvalid;

        // Thermal flag follows the detector level
        n.tsd = over_temp;

        // Open/short detection, paced by the serial clock pulses
        n.scl_q = serial_clk;
        if (s_r.det_busy && s_r.ctrl_det) begin
            if (serial_clk && !s_r.scl_q) begin
                n.det_act = 1'b1;
            end else if (!serial_clk && s_r.scl_q && s_r.det_act) begin
                n.det_act = 1'b0;
                for (int p = 0; p < lmsc_pkg::LINES; p++) begin
                    if (4'(p) != s_r.det_line) begin
                        n.ores[s_r.det_line][pin_col(s_r.det_line, 4'(p))] =
                            open_cmp[p] & s_r.omask[s_r.det_line][pin_col(s_r.det_line, 4'(p))];
                        n.sres[s_r.det_line][pin_col(s_r.det_line, 4'(p))] =
                            short_cmp[p] & s_r.smask[s_r.det_line][pin_col(s_r.det_line, 4'(p))];
                    end
                end
                if (s_r.det_line == lmsc_pkg::LAST_LINE) begin
                    n.det_busy = 1'b0;
                end else begin
                    n.det_line = 4'(s_r.det_line + 4'h1);
                end
            end
        end else begin
            n.det_act = 1'b0;
            if (!n.ctrl_det) begin
                n.det_busy = 1'b0;
            end
        end

        // Display scan: one line per phase, latch reloaded every cycle from the active line
        running = n.ctrl_osc && n.ctrl_disp && !n.tsd && !n.ctrl_det;
        n.sync_out = 1'b0;
        if (running) begin
            if (s_r.ph_cnt >= PH_LAST) begin
                n.ph_cnt = 16'h0000;
                n.line   = (s_r.line >= lmsc_pkg::LAST_LINE) ? 4'h0 : 4'(s_r.line + 4'h1);
                n.sync_out = (n.line == 4'h0);
            end else begin
                n.ph_cnt = 16'(s_r.ph_cnt + 16'h0001);
            end
            for (int c = 0; c < lmsc_pkg::COLS; c++) begin
                gidx = {n.line[3:0], 3'(c)};
                n.latch[c] = n.ctrl_gray ? (n.gray_mem[gidx] != 8'h00) : n.bin_mem[n.line][c];
            end
        end else begin
            n.ph_cnt = 16'h0000;
            n.line   = 4'h0;
            n.latch  = 8'h00;
        end

        // Pin drive: out=1 oe=1 high, out=0 oe=1 sink, oe=0 floats
        n.pin_out = 9'h000;
        n.pin_oe  = 9'h000;
        for (int p = 0; p < lmsc_pkg::LINES; p++) begin
            if (n.tsd) begin
                n.pin_oe[p] = 1'b0;
            end else if (n.det_act) begin
                n.pin_out[p] = (4'(p) == n.det_line);
                n.pin_oe[p]  = 1'b1;
            end else if (running) begin
                n.pin_out[p] = (4'(p) == n.line);
                n.pin_oe[p]  = (4'(p) == n.line) || n.latch[pin_col(n.line, 4'(p))];
            end
        end
        s_nxt = n;
    end

    // ----------------------------------------------------------------
    // Registers; memories and mask stores survive reset
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r          <= '0;
            s_r.bin_mem  <= s_r.bin_mem;
            s_r.gray_mem <= s_r.gray_mem;
            s_r.omask    <= s_r.omask;
            s_r.smask    <= s_r.smask;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign s_axi_awready        = s_r.awready;
    assign s_axi_wready         = s_r.wready;
    assign s_axi_bvalid         = s_r.bvalid;
    assign s_axi_bresp          = s_r.bresp;
    assign s_axi_arready        = s_r.arready;
    assign s_axi_rvalid         = s_r.rvalid;
    assign s_axi_rdata          = s_r.rdata;
    assign s_axi_rresp          = s_r.rresp;
    assign matrix_line_pins_o   = s_r.pin_out;
    assign matrix_line_pins_oe  = s_r.pin_oe;
    assign sync_o               = s_r.sync_out;
    assign sync_oe              = s_r.sync_out; // Driven only while pulsing
    assign thermal_shutdown_flag = s_r.tsd;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    // Case equality: memory holds no defined value until software writes it
    a_reset_keeps_mem: assert property (@(posedge aclk) !aresetn |=> s_r.bin_mem === $past(s_r.bin_mem))
        else $error("display memory changed by reset");
    a_reset_pins_hiz: assert property (@(posedge aclk) !aresetn |=> (s_r.pin_oe == 9'h000) && !sync_oe)
        else $error("pins driven after reset");
    a_reset_disp_off: assert property (@(posedge aclk) !aresetn |=> !s_r.ctrl_disp && !s_r.ctrl_osc)
        else $error("display or oscillator on after reset");
    a_osc_stop_idle: assert property (@(posedge aclk) disable iff (!aresetn)
        (!s_r.ctrl_osc && !s_r.det_act) |-> (s_r.pin_oe == 9'h000))
        else $error("pins driven with oscillator stopped");
    a_one_line_high: assert property (@(posedge aclk) disable iff (!aresetn)
        $onehot0(s_r.pin_out & s_r.pin_oe))
        else $error("more than one line driven high");
    a_phase_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_r.ctrl_osc && s_r.ctrl_disp && !s_r.ctrl_det && !over_temp && s_r.ph_cnt < PH_LAST
         && $stable(s_r.ctrl_disp)) |=> (s_r.line == $past(s_r.line) || !s_r.ctrl_disp || s_r.ctrl_det))
        else $error("line changed inside a phase");
    a_tsd_blank: assert property (@(posedge aclk) disable iff (!aresetn)
        over_temp |=> s_r.tsd && (s_r.pin_oe == 9'h000))
        else $error("overheat did not blank");
    a_tsd_release: assert property (@(posedge aclk) disable iff (!aresetn)
        !over_temp |=> !thermal_shutdown_flag)
        else $error("thermal flag not cleared");
    a_bin_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_go && s_r.w_lane0 && s_r.aw_addr == lmsc_pkg::REG_DATA && !s_r.ctrl_gray && !rd_go
         && s_r.ptr == lmsc_pkg::BIN_LAST_ADDR) |=> s_r.ptr == lmsc_pkg::ADDR_WRAP)
        else $error("binary pointer did not wrap");
    a_gray_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_go && s_r.w_lane0 && s_r.aw_addr == lmsc_pkg::REG_DATA && s_r.ctrl_gray && !rd_go
         && s_r.ptr == lmsc_pkg::GRAY_LAST_ADDR) |=> s_r.ptr == lmsc_pkg::ADDR_WRAP)
        else $error("gray pointer did not wrap");
    a_gray_gap_kept: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_go && s_r.aw_addr == lmsc_pkg::REG_DATA && s_r.ctrl_gray && !gray_mapped(s_r.ptr))
        |=> s_r.gray_mem === $past(s_r.gray_mem))
        else $error("gap write disturbed gray memory");
    a_det_step: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_r.det_busy && s_r.ctrl_det && s_r.det_act && s_r.scl_q && !serial_clk
         && s_r.det_line < lmsc_pkg::LAST_LINE && !wr_go) |=> s_r.det_line == $past(s_r.det_line) + 4'h1)
        else $error("detection line did not step");
endmodule // lmsc_core

`default_nettype wire

// ==== tb/lmsc_led_model.sv ====
// Behavioural LED matrix on the core's line pins: reports injected faults.
// Assumes the core drives pins as o/oe pairs; faults come from the bench.
`timescale 1ns/10ps
`default_nettype none
module lmsc_led_model (
    // Core pins
    input  wire logic [8:0] pin_o,
    input  wire logic [8:0] pin_oe,
    // Injected faults
    input  wire logic [8:0] open_flt,
    input  wire logic [8:0] short_flt,
    // Comparator results
    output logic [8:0]      open_cmp,
    output logic [8:0]      short_cmp
);
    // Only a sinking pin carries LED current, so high or floating pins read clean
    assign open_cmp  = pin_oe & ~pin_o & open_flt;
    assign short_cmp = pin_oe & ~pin_o & short_flt;
endmodule // lmsc_led_model
`default_nettype wire

// ==== tb/led_matrix_scan_core_bench.sv ====
// Self-checking bench for the LED matrix scan core.
// Assumes the LED model on the pins and an AXI4-Lite master in tasks.
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin num_errors++; $display("unexpected %s exp %h got %h", n, e, g); end end
module led_matrix_scan_core_bench;
    logic        aclk = 0, aresetn = 0;
    logic [11:0] aw = 0, ar = 0;
    logic [31:0] wd = 0, rdata, d;
    logic [8:0]  po, poe, oc, sc, fo = 0, fs = 0;
    logic [3:0]  ws = 4'hf;
    logic [1:0]  bresp, rresp, bq, rq;
    logic        awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, ot = 0, sck = 0;
    logic        awr, wrd, bv, arr, rv, so, soe, tsf;
    int          num_errors = 0, cmp_count = 0, cyc = 0, n, m;

    always #4 aclk = ~aclk;
    lmsc_core #(.PHASE_CYCLES(4)) dut (.aclk, .aresetn, .s_axi_awaddr(aw), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrd),
        .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ar), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rre),
        .over_temp(ot), .serial_clk(sck), .open_cmp(oc), .short_cmp(sc), .matrix_line_pins_o(po),
        .matrix_line_pins_oe(poe), .sync_o(so), .sync_oe(soe), .thermal_shutdown_flag(tsf));
    lmsc_led_model led (.pin_o(po), .pin_oe(poe), .open_flt(fo), .short_flt(fs), .open_cmp(oc), .short_cmp(sc));

    task automatic finish_test;
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Whole run needs well under 2000 cycles
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            num_errors++;
            finish_test();
        end
    end

    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        aw <= a;
        wd <= v;
        awv <= 1;
        wv <= 1;
        bre <= 1;
        do begin
            @(posedge aclk);
            if (awr) awv <= 0;
            if (wrd) wv <= 0;
        end while (bv !== 1'b1);
        bq = bresp;
        bre <= 0;
        // Let an edge pass so a following call never re-drives bready in this step
        @(posedge aclk);
    endtask

    task automatic rd(input logic [11:0] a);
        ar <= a;
        arv <= 1;
        rre <= 1;
        do @(posedge aclk); while (arr !== 1'b1);
        arv <= 0;
        do @(posedge aclk); while (rv !== 1'b1);
        d = rdata;
        rq = rresp;
        rre <= 0;
        @(posedge aclk);
    endtask

    task automatic rc(input logic [11:0] a, input logic [31:0] e);
        rd(a);
        `CHK("rdata", e, d)
    endtask

    task automatic t_reset;
        `CHK("oe", 9'h000, poe)
        `CHK("sync oe", 1'b0, soe)
        `CHK("flag", 1'b0, tsf)
        rc(12'h000, 32'h0000_0000);
        rc(12'h00C, 32'h0000_0000);
        `CHK("oe", 9'h000, poe)
        $display("reset defaults done");
    endtask

    task automatic t_binary;
        wr(12'h004, 32'h0000_0000);
        for (int i = 1; i <= 10; i++)
            wr(12'h008, 32'(i));
        wr(12'h004, 32'h0000_0000);
        rc(12'h008, 32'h0000_000a);
        rc(12'h008, 32'h0000_0002);
        wr(12'h000, 32'h0000_0003);
        while ((po[0] & poe[0]) !== 1'b1) @(posedge aclk);
        `CHK("line0 oe", 9'h015, poe)
        `CHK("line0 o", 9'h001, po)
        n = 0;
        m = 0;
        repeat (36) begin
            @(posedge aclk);
            n += po[0] & poe[0];
            m += so & soe;
        end
        `CHK("line0 cycles", 4, n)
        `CHK("sync pulses", 1, m)
        ot <= 1;
        repeat (3) @(posedge aclk);
        `CHK("flag", 1'b1, tsf)
        `CHK("oe", 9'h000, poe)
        rc(12'h00C, 32'h0000_0001);
        ot <= 0;
        repeat (3) @(posedge aclk);
        `CHK("flag", 1'b0, tsf)
        `CHK("scan on", 1'b1, |poe)
        aresetn <= 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        rc(12'h000, 32'h0000_0000);
        rc(12'h008, 32'h0000_000a);
        $display("binary, scan and thermal done");
    endtask

    task automatic t_gray;
        wr(12'h000, 32'h0000_0004);
        wr(12'h004, 32'h0000_0087);
        ws <= 4'h0;
        wr(12'h008, 32'h0000_0011);
        ws <= 4'hf;
        wr(12'h004, 32'h0000_0087);
        wr(12'h008, 32'h0000_0055);
        wr(12'h008, 32'h0000_0066);
        wr(12'h004, 32'h0000_0008);
        wr(12'h008, 32'h0000_0077);
        wr(12'h004, 32'h0000_0087);
        rc(12'h008, 32'h0000_0055);
        rc(12'h008, 32'h0000_0066);
        wr(12'h004, 32'h0000_0008);
        rc(12'h008, 32'h0000_0000);
        wr(12'h200, 32'h0000_0000);
        `CHK("bresp", lmsc_pkg::RESP_SLVERR, bq)
        rd(12'h200);
        `CHK("rresp", lmsc_pkg::RESP_SLVERR, rq)
        $display("gray and unmapped done");
    endtask

    task automatic t_detect;
        for (int i = 0; i < 9; i++) begin
            wr(12'h040 + 12'(4 * i), (i == 0) ? 32'h0000_00ff : 32'h0000_0000);
            wr(12'h080 + 12'(4 * i), (i == 8) ? 32'h0000_00ff : 32'h0000_0000);
        end
        fo <= 9'h004;
        fs <= 9'h001;
        wr(12'h000, 32'h0000_0009);
        repeat (9) begin
            sck <= 1;
            repeat (3) @(posedge aclk);
            sck <= 0;
            repeat (3) @(posedge aclk);
        end
        rc(12'h00C, 32'h0000_0000);
        rc(12'h0C0, 32'h0000_0002);
        rc(12'h0C4, 32'h0000_0000);
        rc(12'h120, 32'h0000_0001);
        rc(12'h104, 32'h0000_0000);
        $display("detection done");
    endtask

    initial begin
        // Bus stays quiet until reset has settled
        repeat (20) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        t_reset();
        t_binary();
        t_gray();
        t_detect();
        finish_test();
    end
endmodule // led_matrix_scan_core_bench
`default_nettype wire
